/* pkg/decom_pkg.sv */
// constants, enums and records of the telemetry frame decommutator
// assumes a 100 MHz ref_clk and a single serial line input
package decom_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WORDS_PER_FRAME = 64;
  localparam int unsigned WORD_BITS = 9;
  localparam int unsigned FRAME_BITS = 576;
  localparam int unsigned SYNC_BITS = 18;
  localparam int unsigned WL_MIN = 4;
  // nominal rate in centi-bps, frame and subframe periods as printed
  localparam longint unsigned NOM_RATE_CBPS = 64'd18799;
  localparam int unsigned FRAME_PERIOD_MS = 3060;
  localparam int unsigned SUB32_PERIOD_CMIN = 163;
  localparam int unsigned SUB64_PERIOD_CMIN = 326;
  localparam int unsigned NOM_BIT_CYCLES =
    int'((64'd100 * CLK_HZ) / NOM_RATE_CBPS);
  localparam int unsigned MIN_RATE_BPS = 10;
  localparam int unsigned MAX_RATE_BPS = 1_000_000;
  localparam logic [23:0] MIN_BIT_CYCLES = 24'(CLK_HZ / MAX_RATE_BPS);
  localparam logic [23:0] MAX_BIT_CYCLES = 24'(CLK_HZ / MIN_RATE_BPS);
  localparam int unsigned JITTER_PCT = 20;
  localparam logic [5:0] SLOT_SYNC_B = 6'h01;
  localparam logic [5:0] SLOT_MODE = 6'h02;
  localparam logic [5:0] SLOT_CMD = 6'h03;
  localparam logic [5:0] SLOT_LAST_DIG = 6'h0f;
  localparam logic [5:0] SLOT_SUB64 = 6'h1c;
  localparam logic [5:0] SLOT_SUB32 = 6'h3c;
  localparam logic [4:0] SUB32_DIGITAL = 5'h04;
  localparam int unsigned DWELL_BIT = 8;
  localparam logic [1:0] LOCK_HITS = 2'h2;
  localparam logic [1:0] MISS_LIMIT = 2'h3;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [2:0] {code_nrz_l, code_nrz_m, code_rz, code_sp_l, code_sp_m} line_code_e;
  typedef enum logic [1:0] {fs_search, fs_verify, fs_locked} frame_state_e;
  typedef enum logic [3:0] {
    cls_sync, cls_digital, cls_mode, cls_cmd, cls_analog, cls_sub64,
    cls_sub32_analog, cls_sub32_digital, cls_dwell
  } word_class_e;

  typedef struct packed {
    logic [8:0] data;
    logic [5:0] slot;
    logic [5:0] sub_idx;
    logic sub_valid;
    logic dwell;
    word_class_e cls;
  } word_rec_s;
endpackage

/* core/telemetry_frame_decommutator.sv */
// bit recovery, frame sync and word routing for serial pcm telemetry
// assumes line_in is asynchronous; config inputs are steady on ref_clk
`timescale 1ns/1ps

module decom_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input logic ref_clk,
  input logic nrst,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_s;
  fifo_state_s q, n;
  logic push, pop;

  assign in_ready = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = in_data;
      n.wp = q.wp + 1'b1;
    end
    if (pop) n.rp = q.rp + 1'b1;
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  AST_FIFO_FULL: assert property (@(posedge ref_clk) disable iff (!nrst)
    (q.cnt == (AW+1)'(DEPTH)) && !pop |=> !in_ready && $stable(q.cnt))
    else $error("fifo count moved while full");
endmodule

module telemetry_frame_decommutator #(
  parameter int unsigned NOM_BIT_CYCLES = decom_pkg::NOM_BIT_CYCLES
) (
  input logic ref_clk,
  input logic nrst,
  input logic line_in,
  input decom_pkg::line_code_e cfg_code,
  input logic [23:0] cfg_bit_cycles,
  input logic [3:0] cfg_word_len,
  input logic [17:0] cfg_sync,
  input logic [7:0] cmd_expected,
  input logic out_ready,
  output logic out_valid,
  output decom_pkg::word_rec_s out_rec,
  output logic locked,
  output logic lock_lost,
  output logic overrun,
  output logic cmd_valid,
  output logic [8:0] cmd_word,
  output logic cmd_match
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [23:0] ph;
    logic smp;
    logic prev_smp;
    logic [17:0] sh;
    logic [8:0] wsh;
    logic [5:0] slot;
    logic [3:0] bpos;
    decom_pkg::frame_state_e fs;
    logic [1:0] hits;
    logic [1:0] miss;
    logic [8:0] mode;
    logic lost;
    logic ovr;
    logic cmd_v;
    logic [8:0] cmd_w;
    logic cmd_m;
    logic push;
    decom_pkg::word_rec_s rec;
  } top_state_s;

  top_state_s q, n;
  logic [23:0] per, edge_pos, win, samp_pos;
  logic [3:0] wl;
  logic [9:0] spos;
  logic split, strobe, bitv, fin_ready;

  // advance a (slot, bit) position by one bit at word length w
  function automatic logic [9:0] nxt_pos(input logic [9:0] p, input logic [3:0] w);
    logic [9:0] r;
    r = p;
    if (p[3:0] == w - 4'h1) begin
      r = {p[9:4] + 6'h01, 4'h0};
    end else begin
      r[3:0] = p[3:0] + 4'h1;
    end
    return r;
  endfunction

  // position of the last sync bit; sync sits at the head of the frame
  function automatic logic [9:0] sync_pos(input logic [3:0] w);
    logic [9:0] r;
    r = '0;
    for (int i = 0; i < decom_pkg::SYNC_BITS - 1; i++) begin
      r = nxt_pos(r, w);
    end
    return r;
  endfunction

  function automatic logic in_win(input logic [23:0] ph, input logic [23:0] e,
                                  input logic [23:0] w, input logic [23:0] p);
    if (e == '0) begin
      return (ph <= w) || (ph >= p - w);
    end
    return (ph >= e - w) && (ph <= e + w);
  endfunction

  function automatic decom_pkg::word_rec_s classify(input logic [5:0] slot,
                                                    input logic [8:0] mode,
                                                    input logic [8:0] data);
    decom_pkg::word_rec_s r;
    r.data = data;
    r.slot = slot;
    r.dwell = mode[decom_pkg::DWELL_BIT];
    r.sub_valid = !r.dwell && (slot == decom_pkg::SLOT_SUB64 || slot == decom_pkg::SLOT_SUB32);
    // the mode word counts entries, so index follows one step per frame
    r.sub_idx = (slot == decom_pkg::SLOT_SUB32) ? {1'b0, mode[4:0]} : mode[5:0];
    if (slot <= decom_pkg::SLOT_SYNC_B) r.cls = decom_pkg::cls_sync;
    else if (slot == decom_pkg::SLOT_MODE) r.cls = decom_pkg::cls_mode;
    else if (slot == decom_pkg::SLOT_CMD) r.cls = decom_pkg::cls_cmd;
    else if (r.dwell) r.cls = decom_pkg::cls_dwell;
    else if (slot <= decom_pkg::SLOT_LAST_DIG) r.cls = decom_pkg::cls_digital;
    else if (slot == decom_pkg::SLOT_SUB64) r.cls = decom_pkg::cls_sub64;
    else if (slot == decom_pkg::SLOT_SUB32) r.cls = (mode[4:0] < decom_pkg::SUB32_DIGITAL)
      ? decom_pkg::cls_sub32_digital : decom_pkg::cls_sub32_analog;
    else r.cls = decom_pkg::cls_analog;
    return r;
  endfunction

  always_comb begin
    if (cfg_bit_cycles == '0) per = 24'(NOM_BIT_CYCLES);
    else if (cfg_bit_cycles < decom_pkg::MIN_BIT_CYCLES) per = decom_pkg::MIN_BIT_CYCLES;
    else if (cfg_bit_cycles > decom_pkg::MAX_BIT_CYCLES) per = decom_pkg::MAX_BIT_CYCLES;
    else per = cfg_bit_cycles;
  end

  // word lengths outside 4 to 9 fall back to the telemetry format of 9 bits
  assign wl = (cfg_word_len < 4'(decom_pkg::WL_MIN) || cfg_word_len > 4'(decom_pkg::WORD_BITS))
              ? 4'(decom_pkg::WORD_BITS) : cfg_word_len;
  assign spos = sync_pos(wl);
  assign split = (cfg_code == decom_pkg::code_sp_l) || (cfg_code == decom_pkg::code_sp_m);
  // split-phase always toggles mid-bit, so track that edge, not the boundary
  assign edge_pos = split ? (per >> 1) : '0;
  assign win = 24'((32'(per) * decom_pkg::JITTER_PCT) / 32'd100);
  assign samp_pos = (cfg_code == decom_pkg::code_nrz_l || cfg_code == decom_pkg::code_nrz_m)
                    ? (per >> 1) : (per >> 2);
  assign strobe = q.ph >= per - 24'h1;
  // mark variants carry a one as a change of level
  assign bitv = (cfg_code == decom_pkg::code_nrz_m || cfg_code == decom_pkg::code_sp_m)
                ? (q.smp ^ q.prev_smp) : q.smp;

  always_comb begin
    logic [8:0] wdat;
    logic word_end;
    logic at_chk;
    logic hit;
    wdat = '0;
    word_end = 1'b0;
    at_chk = 1'b0;
    hit = 1'b0;
    n = q;
    n.s1 = line_in;
    n.s2 = q.s1;
    n.lvl = q.s2;
    n.lost = 1'b0;
    n.cmd_v = 1'b0;
    n.push = 1'b0;
    if (q.s2 != q.lvl && in_win(q.ph, edge_pos, win, per)) n.ph = edge_pos;
    else if (strobe) n.ph = '0;
    else n.ph = q.ph + 24'h1;
    if (q.ph == samp_pos) n.smp = q.s2;
    if (strobe) begin
      n.prev_smp = q.smp;
      n.sh = {q.sh[16:0], bitv};
      n.wsh = {q.wsh[7:0], bitv};
      wdat = {q.wsh[7:0], bitv} & ~(9'h1ff << wl);
      word_end = q.bpos == wl - 4'h1;
      at_chk = {q.slot, q.bpos} == spos;
      hit = n.sh == cfg_sync;
      {n.slot, n.bpos} = nxt_pos({q.slot, q.bpos}, wl);
      case (q.fs)
        decom_pkg::fs_search: begin
          if (hit) begin
            n.fs = decom_pkg::fs_verify;
            n.hits = 2'h1;
            {n.slot, n.bpos} = nxt_pos(spos, wl);
          end
        end
        decom_pkg::fs_verify: begin
          if (at_chk && !hit) begin
            n.fs = decom_pkg::fs_search;
          end else if (at_chk && q.hits == decom_pkg::LOCK_HITS - 2'h1) begin
            n.fs = decom_pkg::fs_locked;
            n.miss = '0;
            n.ovr = 1'b0;
          end else if (at_chk) begin
            n.hits = q.hits + 2'h1;
          end
        end
        decom_pkg::fs_locked: begin
          if (at_chk && hit) begin
            n.miss = '0;
          end else if (at_chk && q.miss == decom_pkg::MISS_LIMIT - 2'h1) begin
            n.fs = decom_pkg::fs_search;
            n.lost = 1'b1;
          end else if (at_chk) begin
            n.miss = q.miss + 2'h1;
          end
        end
        default: n.fs = decom_pkg::fs_search;
      endcase
      if (q.fs == decom_pkg::fs_locked && word_end) begin
        if (q.slot == decom_pkg::SLOT_MODE) n.mode = wdat;
        if (q.slot == decom_pkg::SLOT_CMD) begin
          n.cmd_v = 1'b1;
          n.cmd_w = wdat;
          n.cmd_m = wdat[7:0] == cmd_expected;
        end
        n.push = 1'b1;
        n.rec = classify(q.slot, (q.slot == decom_pkg::SLOT_MODE) ? wdat : q.mode, wdat);
      end
    end
    // a drop that meets the lock entry clear still leaves the flag set
    if (q.push && !fin_ready) n.ovr = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // the line cannot be stalled, so a full fifo drops the word and flags it
  decom_fifo #(.W($bits(decom_pkg::word_rec_s)), .DEPTH(decom_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(q.push),
    .in_ready(fin_ready),
    .in_data(q.rec),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_rec)
  );

  assign locked = q.fs == decom_pkg::fs_locked;
  assign lock_lost = q.lost;
  assign overrun = q.ovr;
  assign cmd_valid = q.cmd_v;
  assign cmd_word = q.cmd_w;
  assign cmd_match = q.cmd_m;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence quiet8;
    !strobe [*8];
  endsequence

  AST_SLOT_WRAP: assert property (strobe && q.fs != decom_pkg::fs_search && q.slot == 6'h3f
    && q.bpos == wl - 4'h1 |=> q.slot == 6'h00 && q.bpos == 4'h0)
    else $error("slot counter did not wrap after word 63");
  AST_BIT_RANGE: assert property (q.fs != decom_pkg::fs_search |-> q.bpos < wl)
    else $error("bit position beyond word length");
  AST_STROBE_GAP: assert property (strobe |=> quiet8)
    else $error("bit strobes closer than minimum bit period");
  AST_LOST: assert property (lock_lost |-> !locked && $past(locked))
    else $error("lock loss without prior lock");
  AST_CMD_CMP: assert property (cmd_valid |-> cmd_match == (cmd_word[7:0] == $past(cmd_expected))
    && $past(q.slot) == decom_pkg::SLOT_CMD)
    else $error("command compare wrong");
  AST_SUB64: assert property (q.push && !q.rec.dwell && q.rec.slot == decom_pkg::SLOT_SUB64
    |-> q.rec.cls == decom_pkg::cls_sub64 && q.rec.sub_valid)
    else $error("sub64 word misclassed");
  AST_SUB32: assert property (q.push && q.rec.cls == decom_pkg::cls_sub32_digital
    |-> q.rec.slot == decom_pkg::SLOT_SUB32 && q.rec.sub_idx < 6'(decom_pkg::SUB32_DIGITAL))
    else $error("sub32 digital entry out of range");
  AST_DWELL: assert property (q.push && q.rec.dwell && q.rec.slot > decom_pkg::SLOT_CMD
    |-> q.rec.cls == decom_pkg::cls_dwell && !q.rec.sub_valid)
    else $error("dwell sample not routed as dwell");
  AST_PUSH_LOCKED: assert property (q.push |-> $past(locked))
    else $error("word emitted without lock");
endmodule

/* tb/pcm_source.sv */
// frame source standing in for the spacecraft telemetry transmitter
// starts at the first release of nrst and keeps sending through later resets
`timescale 1ns/1ps
module pcm_source #(
  parameter int P = 100,
  parameter logic [17:0] SYNC = 18'h3fe01,
  parameter logic [8:0] MODE = 9'h005,
  parameter logic [8:0] CMD = 9'h05a
) (
  input logic ref_clk,
  input logic nrst,
  output logic line_out
);
  logic [8:0] w;

  // filler words of 101 and the slot keep runs of ones short of the sync
  function automatic logic [8:0] word_at(input int s);
    if (s == 0) return SYNC[17:9];
    if (s == 1) return SYNC[8:0];
    if (s == 2) return MODE;
    if (s == 3) return CMD;
    return {3'h5, 6'(s)};
  endfunction

  initial begin
    line_out = 1'b0;
    @(posedge nrst);
    @(posedge ref_clk);
    forever begin
      for (int s = 0; s < 64; s++) begin
        w = word_at(s);
        for (int i = 8; i >= 0; i--) begin
          // first half carries the bit, second half its inverse
          line_out <= w[i];
          repeat (P / 2) @(posedge ref_clk);
          line_out <= ~w[i];
          repeat (P / 2) @(posedge ref_clk);
        end
      end
    end
  end
endmodule

/* tb/tb.sv */
// self-checking bench: lock, fifo overrun and drain, command readback, reset
// assumes pcm_source on line_in and a 100 clock bit period
`timescale 1ns/1ps
module tb;
  localparam int P = 100;
  localparam logic [17:0] SYNC = 18'h3fe01;
  localparam logic [8:0] MODE = 9'h005;
  localparam logic [8:0] CMD = 9'h05a;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic line_in;
  logic out_ready = 1'b0;
  logic out_valid;
  decom_pkg::word_rec_s out_rec;
  logic locked;
  logic lock_lost;
  logic overrun;
  logic cmd_valid;
  logic [8:0] cmd_word;
  logic cmd_match;
  int err_total = 0;
  int num_checks = 0;
  int cmd_seen = 0;

  always #5 ref_clk = ~ref_clk;

  pcm_source #(.P(P), .SYNC(SYNC), .MODE(MODE), .CMD(CMD)) src (
    .ref_clk(ref_clk), .nrst(nrst), .line_out(line_in));

  telemetry_frame_decommutator dut (
    .ref_clk(ref_clk), .nrst(nrst), .line_in(line_in),
    .cfg_code(decom_pkg::code_sp_l), .cfg_bit_cycles(24'h000064),
    .cfg_word_len(4'h9), .cfg_sync(SYNC), .cmd_expected(CMD[7:0]),
    .out_ready(out_ready), .out_valid(out_valid), .out_rec(out_rec),
    .locked(locked), .lock_lost(lock_lost), .overrun(overrun),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_match(cmd_match));

  always @(negedge ref_clk) begin
    if (cmd_valid === 1'b1) begin
      cmd_seen++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [8:0] exp_word(input int s);
    if (s == 2) return MODE;
    if (s == 3) return CMD;
    return {3'h5, 6'(s)};
  endfunction

  function automatic logic [3:0] exp_cls(input int s);
    if (s == 2) return 4'h2;
    if (s == 3) return 4'h3;
    if (s <= 15) return 4'h1;
    if (s == 28) return 4'h5;
    return 4'h4;
  endfunction

  task automatic pop_check(input int s);
    int n;
    decom_pkg::word_rec_s r;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (out_valid !== 1'b1 && n < 2000);
    r = out_rec;
    check(32'(out_valid), 1, "valid");
    check(32'(r.slot), 32'(s), "slot");
    check(32'(r.data), 32'(exp_word(s)), "data");
    check(32'(r.cls), 32'(exp_cls(s)), "class");
    check(32'(r.dwell), 0, "dwell");
    check(32'(r.sub_valid), 32'(s == 28), "sub valid");
    if (s == 28) begin
      check(32'(r.sub_idx), 32'(MODE[5:0]), "sub index");
    end
  endtask

  // lock comes only with the second frame's sync, nothing leaks before it
  task automatic wait_lock();
    int n;
    logic early;
    n = 0;
    early = 1'b0;
    while (locked !== 1'b1 && n < 70000) begin
      @(negedge ref_clk);
      n++;
      if (out_valid !== 1'b0 || lock_lost !== 1'b0) early = 1'b1;
    end
    check(32'(locked), 1, "locked");
    check(32'(early), 0, "output before lock");
    check(32'(n > 593 * P && n < 596 * P), 1, "lock time");
  endtask

  // consumer stalls: slots 2..17 fill the fifo, slot 18 is dropped
  task automatic fill_and_drain();
    int n;
    n = 0;
    while (overrun !== 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    check(32'(overrun), 1, "overrun");
    check(32'(n > 152 * P && n < 155 * P), 1, "overrun time");
    @(posedge ref_clk);
    out_ready <= 1'b1;
    for (int s = 2; s <= 17; s++) pop_check(s);
    for (int s = 19; s <= 28; s++) pop_check(s);
    check(32'(overrun), 1, "overrun sticky");
    check(32'(locked), 1, "still locked");
  endtask

  task automatic check_cmd();
    check(32'(cmd_seen), 1, "cmd pulses");
    check(32'(cmd_word), 32'(CMD), "cmd word");
    check(32'(cmd_match), 1, "cmd match");
  endtask

  // a reset in mid-run drops lock, clears the flags and keeps the output quiet
  task automatic reset_check();
    logic bad;
    bad = 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (4) @(negedge ref_clk);
    check(32'(locked), 0, "locked in reset");
    check(32'(overrun), 0, "overrun in reset");
    check(32'(cmd_valid), 0, "cmd pulse in reset");
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (300) begin
      @(negedge ref_clk);
      if (out_valid !== 1'b0 || locked !== 1'b0 || lock_lost !== 1'b0) bad = 1'b1;
    end
    check(32'(bad), 0, "output after reset");
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_lock();
    fill_and_drain();
    check_cmd();
    reset_check();
    stop_test();
  end

  // whole run is about 84k cycles
  initial begin
    #1_000_000;
    err_total++;
    stop_test();
  end
endmodule
